//--- rtl/ubin_bank.sv
// One 64-byte FIFO bank: byte store with fill counter and read pointer.
// Assumes writes and reads never target the same bank in one cycle.
`timescale 1ns/100ps
module ubin_bank
  import ubin_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  clear,
  input  wire logic                  rewind,
  input  wire logic                  wr_en,
  input  wire logic [7:0]            wr_data,
  input  wire logic                  rd_en,
  output logic [7:0]                 rd_data,
  output logic [UBIN_CNT_W-1:0]      count,
  output logic                       left_empty
);

  logic [7:0]            mem_reg [UBIN_BANK_BYTES];
  logic [UBIN_CNT_W-1:0] cnt_reg;
  logic [UBIN_CNT_W-1:0] rp_reg;

  assign count      = cnt_reg;
  assign rd_data    = mem_reg[rp_reg[5:0]];
  assign left_empty = (rp_reg == cnt_reg);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      rp_reg  <= '0;
    end else if (clear) begin
      cnt_reg <= '0;
      rp_reg  <= '0;
    end else begin
      if (wr_en) cnt_reg <= cnt_reg + 7'h01;
      if (rewind) rp_reg <= '0;
      else if (rd_en) rp_reg <= rp_reg + 7'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (wr_en) mem_reg[cnt_reg[5:0]] <= wr_data;
  end

endmodule : ubin_bank

//--- rtl/ubin_ctrl.sv
// Bulk IN NAK control, two-bank toggle, DMA request and endpoint-4 status.
// Assumes an 8-bit register port, a DMA controller and a serial engine on clock.
//
// How it works
// - NAK bit 1 lets the engine send data; 0 makes it NAK IN tokens.
// - NAK bit clears on buffer clear, or when a packet is acknowledged and the CPU bank is not complete.
// - Every toggle sets the NAK bit; sent data kept until acknowledged.
// - Toggle needs CPU bank complete (full or data-end) and engine bank empty.
// - A programmed write, or a DMA write with transfer-end 1, that fills the CPU bank toggles and sets the NAK bit.
// - DMA fill with transfer-end 0 waits for the write-done bit.
// - Write-done from firmware toggles banks and sets the NAK bit together.
// - Clearing the bulk IN buffer clears the NAK bit at once.
// - Enabling DMA during a programmed write raises the request at once.
// - Once the CPU bank holds 64 bytes from any source the request drops; it returns on toggle unless masked.
// - Without transfer-end bit after a DMA fill, data waits for write-done.
// - Terminal count drops and masks the request; firmware unmasks it.
// - GET_STATUS for endpoint 4 returns the status register without firmware.
// - Status register is 8-bit; writes act only while ep0 NAK-all is 1.
// - An endpoint-4 error sets the halt bit 0; reset value 00H.
// - CPU writes to the status register are ignored while a USB access to endpoint 4 is received.
// - On stall the bulk OUT buffer is cleared and its NAK bit cleared.
// - Writes masked during non-control transfers to endpoint 4; read back.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
module ubin_ctrl
  import ubin_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // DMA side
  input  wire logic        dma_wr,
  input  wire logic [7:0]  dma_wdata,
  input  wire logic        dma_terminal_count,
  output logic             dma_req,
  // Serial engine side
  input  wire logic        sie_in_token,
  input  wire logic        sie_tx_ack,
  input  wire logic        sie_tx_err,
  output logic             sie_nak,
  output logic [7:0]       sie_tx_data,
  output logic             sie_tx_valid,
  input  wire logic        sie_tx_ready,
  output logic             sie_tx_last,
  input  wire logic        ep0_nak_all,
  input  wire logic        ep4_usb_access,
  input  wire logic        ep4_xfer_active,
  input  wire logic        ep4_error,
  input  wire logic        get_status_ep4,
  output logic [7:0]       status_reply,
  output logic             status_reply_valid,
  output logic             bulk_out2_clear,
  output logic             bulk_out2_nak_ctl
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire sel_ctl    = hit(reg_addr, UBIN_BULK_IN_CTL_OFS);
  wire sel_dend   = hit(reg_addr, UBIN_DATA_END_OFS);
  wire sel_data   = hit(reg_addr, UBIN_BULK_IN_DATA_OFS);
  wire sel_out    = hit(reg_addr, UBIN_BULK_OUT_CTL_OFS);
  wire sel_dma    = hit(reg_addr, UBIN_DMA_CTL_OFS);
  wire sel_status = hit(reg_addr, UBIN_EP4_STATUS_LOW_OFS);

  // ---------------------------------------------------------------
  // Input synchronisers for pin-level inputs
  // ---------------------------------------------------------------
  logic [1:0] nka_sync_reg;
  logic [1:0] tc_sync_reg;
  wire        nak_all_s = nka_sync_reg[1];
  wire        tc_s      = tc_sync_reg[1];
  logic       tc_d_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nka_sync_reg <= 2'h0;
      tc_sync_reg  <= 2'h0;
      tc_d_reg     <= 1'b0;
    end else begin
      nka_sync_reg <= {nka_sync_reg[0], ep0_nak_all};
      tc_sync_reg  <= {tc_sync_reg[0], dma_terminal_count};
      tc_d_reg     <= tc_s;
    end
  end

  wire tc_rise = tc_s && !tc_d_reg;

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  logic       nak_ctl_reg;
  logic       xfer_end_reg;
  logic       wr_done_reg;
  logic       dma_en_reg;
  logic       dma_mask_reg;
  logic       dma_req_reg;
  logic       cpu_bank_reg;
  logic       out_nak_reg;
  logic [7:0] status_reg;
  logic       filled_by_dma_reg;
  ubin_tx_e   tx_state_reg;
  ubin_tx_e   tx_state_next;

  // ---------------------------------------------------------------
  // Banks
  // ---------------------------------------------------------------
  logic [UBIN_CNT_W-1:0] cnt [2];
  logic [7:0]            rdd [2];
  logic                  lempty [2];
  wire                   buf_clear = reg_wr && sel_ctl && reg_wdata[UBIN_IN_CLEAR_BIT];
  wire                   pio_wr    = reg_wr && sel_data;
  wire                   any_wr    = pio_wr || dma_wr;
  wire [7:0]             wr_byte   = pio_wr ? reg_wdata : dma_wdata;
  wire                   sie_bank  = ~cpu_bank_reg;
  wire                   cpu_full  = (cnt[cpu_bank_reg] == 7'(UBIN_BANK_BYTES));
  wire                   wr_ok     = any_wr && !cpu_full;
  wire                   skid_ready;
  wire                   rd_pull;
  wire                   tx_done;
  wire                   tx_rewind;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bank
      ubin_bank u_bank (
        .clock      (clock),
        .rst_n      (rst_n),
        .clear      (buf_clear || (tx_done && sie_bank == g[0])),
        .rewind     (tx_rewind && sie_bank == g[0]),
        .wr_en      (wr_ok && cpu_bank_reg == g[0]),
        .wr_data    (wr_byte),
        .rd_en      (rd_pull && sie_bank == g[0]),
        .rd_data    (rdd[g]),
        .count      (cnt[g]),
        .left_empty (lempty[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Toggle decision
  // ---------------------------------------------------------------
  wire dend_wr       = reg_wr && sel_dend;
  wire set_wr_done   = dend_wr && reg_wdata[UBIN_WR_DONE_BIT];
  wire cpu_has_data  = (cnt[cpu_bank_reg] != 7'h00);
  // A DMA fill without transfer-end waits for write-done
  wire full_ok       = cpu_full && !(filled_by_dma_reg && !xfer_end_reg);
  wire complete      = full_ok || (wr_done_reg && cpu_has_data);
  wire sie_empty     = (cnt[sie_bank] == 7'h00);
  wire do_toggle     = complete && sie_empty && !buf_clear;

  // ---------------------------------------------------------------
  // Transmit path through the two-entry buffer
  // ---------------------------------------------------------------
  logic sending;
  assign sending   = (tx_state_reg == UBIN_TX_SEND);
  assign rd_pull   = sending && skid_ready && !lempty[sie_bank] && !sie_empty;
  assign tx_done   = sending && sie_tx_ack;
  assign tx_rewind = sending && sie_tx_err;

  ubin_skid u_skid (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (buf_clear || tx_done || tx_rewind),
    .in_data   (rdd[sie_bank]),
    .in_valid  (rd_pull),
    .in_ready  (skid_ready),
    .out_data  (sie_tx_data),
    .out_valid (sie_tx_valid),
    .out_ready (sie_tx_ready)
  );

  assign sie_tx_last = sending && lempty[sie_bank] && !sie_empty;

  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      UBIN_TX_IDLE: if (sie_in_token && nak_ctl_reg && !sie_empty) tx_state_next = UBIN_TX_SEND;
      UBIN_TX_SEND: if (tx_done || tx_rewind || buf_clear) tx_state_next = UBIN_TX_IDLE;
      default:      tx_state_next = UBIN_TX_IDLE;
    endcase
  end

  assign sie_nak = !nak_ctl_reg;

  // ---------------------------------------------------------------
  // NAK control and bank select
  // ---------------------------------------------------------------
  wire nak_next = do_toggle ? 1'b1 :
                  buf_clear ? 1'b0 :
                  (tx_done && !complete) ? 1'b0 :
                  nak_ctl_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nak_ctl_reg  <= 1'b0;
      cpu_bank_reg <= 1'b0;
      tx_state_reg <= UBIN_TX_IDLE;
    end else begin
      nak_ctl_reg  <= nak_next;
      tx_state_reg <= tx_state_next;
      if (buf_clear) cpu_bank_reg <= 1'b0;
      else if (do_toggle) cpu_bank_reg <= ~cpu_bank_reg;
    end
  end

  // ---------------------------------------------------------------
  // Data-end bits; hardware toggle clears write-done
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      xfer_end_reg      <= UBIN_DATA_END_RST[UBIN_XFER_END_BIT];
      wr_done_reg       <= UBIN_DATA_END_RST[UBIN_WR_DONE_BIT];
      filled_by_dma_reg <= 1'b0;
    end else begin
      if (dend_wr) xfer_end_reg <= reg_wdata[UBIN_XFER_END_BIT];
      if (set_wr_done) wr_done_reg <= 1'b1;
      else if (do_toggle || buf_clear) wr_done_reg <= 1'b0;
      if (do_toggle || buf_clear) filled_by_dma_reg <= 1'b0;
      else if (dma_wr && wr_ok) filled_by_dma_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // DMA request
  // ---------------------------------------------------------------
  wire dma_ctl_wr = reg_wr && sel_dma;
  wire req_next   = dma_en_reg && !dma_mask_reg && !tc_rise && !cpu_full;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dma_en_reg   <= UBIN_DMA_CTL_RST[UBIN_DMA_EN_BIT];
      dma_mask_reg <= UBIN_DMA_CTL_RST[UBIN_DMA_MASK_BIT];
      dma_req_reg  <= 1'b0;
    end else begin
      if (dma_ctl_wr) dma_en_reg <= reg_wdata[UBIN_DMA_EN_BIT];
      if (tc_rise) dma_mask_reg <= 1'b1;
      else if (dma_ctl_wr) dma_mask_reg <= reg_wdata[UBIN_DMA_MASK_BIT];
      dma_req_reg <= req_next;
    end
  end

  assign dma_req = dma_req_reg;

  // ---------------------------------------------------------------
  // Endpoint-4 status and bulk OUT side
  // ---------------------------------------------------------------
  wire st_wr_ok = reg_wr && sel_status && nak_all_s
                  && !ep4_usb_access && !ep4_xfer_active;
  wire halted   = status_reg[UBIN_HALT_BIT];
  logic halted_d_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_reg         <= UBIN_EP4_STATUS_RST;
      halted_d_reg       <= 1'b0;
      out_nak_reg        <= 1'b0;
      status_reply       <= 8'h00;
      status_reply_valid <= 1'b0;
    end else begin
      if (ep4_error) status_reg[UBIN_HALT_BIT] <= 1'b1;
      else if (st_wr_ok) status_reg[UBIN_HALT_BIT] <= reg_wdata[UBIN_HALT_BIT];
      halted_d_reg       <= halted;
      if (halted && !halted_d_reg) out_nak_reg <= 1'b0;
      else if (reg_wr && sel_out) out_nak_reg <= reg_wdata[UBIN_OUT_NAK_BIT];
      status_reply_valid <= get_status_ep4;
      if (get_status_ep4) status_reply <= status_reg;
    end
  end

  assign bulk_out2_clear   = halted && !halted_d_reg;
  assign bulk_out2_nak_ctl = out_nak_reg;

  // ---------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ---------------------------------------------------------------
  wire [7:0] rd_mux =
    sel_status ? status_reg :
    sel_ctl    ? {6'h00, nak_ctl_reg, 1'b0} :
    sel_dend   ? {6'h00, wr_done_reg, xfer_end_reg} :
    sel_out    ? {6'h00, out_nak_reg, 1'b0} :
    sel_dma    ? {6'h00, dma_mask_reg, dma_en_reg} :
    8'h00;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= 8'h00;
  end

endmodule : ubin_ctrl

//--- rtl/ubin_pkg.sv
// Package for the bulk IN NAK/bank-toggle and endpoint-4 status block.
// Assumes a single 200 MHz clock and an 8-bit plain register port.
package ubin_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [31:0] UBIN_EP4_STATUS_LOW_OFS = 32'h0020015C;
  localparam logic [31:0] UBIN_BULK_IN_CTL_OFS    = 32'h00200100;
  localparam logic [31:0] UBIN_DATA_END_OFS       = 32'h00200104;
  localparam logic [31:0] UBIN_BULK_IN_DATA_OFS   = 32'h00200108;
  localparam logic [31:0] UBIN_BULK_OUT_CTL_OFS   = 32'h0020010C;
  localparam logic [31:0] UBIN_DMA_CTL_OFS        = 32'h00200110;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int UBIN_IN_NAK_BIT     = 1;
  localparam int UBIN_IN_CLEAR_BIT   = 0;
  localparam int UBIN_XFER_END_BIT   = 0;
  localparam int UBIN_WR_DONE_BIT    = 1;
  localparam int UBIN_HALT_BIT       = 0;
  localparam int UBIN_OUT_NAK_BIT    = 1;
  localparam int UBIN_DMA_EN_BIT     = 0;
  localparam int UBIN_DMA_MASK_BIT   = 1;
  localparam int UBIN_EP0_NAKALL_BIT = 0;

  // ---------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] UBIN_EP4_STATUS_RST = 8'h00;
  localparam logic [7:0] UBIN_DATA_END_RST   = 8'h00;
  localparam logic [7:0] UBIN_DMA_CTL_RST    = 8'h00;
  localparam int         UBIN_BANK_BYTES     = 64;
  localparam int         UBIN_CNT_W          = 7;

  typedef enum logic [1:0] {UBIN_TX_IDLE, UBIN_TX_SEND} ubin_tx_e;

endpackage : ubin_pkg

//--- rtl/ubin_skid.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes source and sink share the clock.
`timescale 1ns/100ps
module ubin_skid
  import ubin_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       flush,
  input  wire logic [7:0] in_data,
  input  wire logic       in_valid,
  output logic            in_ready,
  output logic [7:0]      out_data,
  output logic            out_valid,
  input  wire logic       out_ready
);

  logic [7:0] mem_reg [2];
  logic       wp_reg;
  logic       rp_reg;
  logic [1:0] cnt_reg;
  wire        push = in_valid && in_ready;
  wire        pop  = out_valid && out_ready;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rp_reg];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (flush) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wp_reg <= ~wp_reg;
      if (pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clock) begin
    if (push) mem_reg[wp_reg] <= in_data;
  end

endmodule : ubin_skid

//--- verification/tb_top.sv
// Self-checking bench for the bulk IN / endpoint-4 status block.
// Assumes the serial engine model and the bound property checker.
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  import ubin_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, dma_wdata = 8'h00, sie_tx_data, status_reply, rv;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, dma_wr = 1'b0, dma_terminal_count = 1'b0;
  logic        ep0_nak_all = 1'b0, ep4_usb_access = 1'b0, ep4_xfer_active = 1'b0;
  logic        ep4_error = 1'b0, get_status_ep4 = 1'b0;
  logic        dma_req, sie_in_token, sie_tx_ack, sie_tx_err, sie_nak, sie_tx_valid;
  logic        sie_tx_ready, sie_tx_last, status_reply_valid, bulk_out2_clear, bulk_out2_nak_ctl;
  int          miscompares = 0, checks = 0, clr_cnt = 0, c0;
  localparam logic [31:0] ST = UBIN_EP4_STATUS_LOW_OFS;
  localparam logic [31:0] DT = UBIN_BULK_IN_DATA_OFS;

  always #2.5 clock = ~clock;
  always @(posedge clock) if (bulk_out2_clear === 1'b1) clr_cnt++;

  ubin_ctrl i_ubin_ctrl (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_wr(dma_wr), .dma_wdata(dma_wdata),
    .dma_terminal_count(dma_terminal_count), .dma_req(dma_req), .sie_in_token(sie_in_token),
    .sie_tx_ack(sie_tx_ack), .sie_tx_err(sie_tx_err), .sie_nak(sie_nak), .sie_tx_data(sie_tx_data),
    .sie_tx_valid(sie_tx_valid), .sie_tx_ready(sie_tx_ready), .sie_tx_last(sie_tx_last),
    .ep0_nak_all(ep0_nak_all), .ep4_usb_access(ep4_usb_access), .ep4_xfer_active(ep4_xfer_active),
    .ep4_error(ep4_error), .get_status_ep4(get_status_ep4), .status_reply(status_reply),
    .status_reply_valid(status_reply_valid), .bulk_out2_clear(bulk_out2_clear),
    .bulk_out2_nak_ctl(bulk_out2_nak_ctl));
  ubin_sie_model i_ubin_sie_model (.clock(clock), .sie_tx_data(sie_tx_data), .sie_tx_valid(sie_tx_valid),
    .sie_in_token(sie_in_token), .sie_tx_ready(sie_tx_ready), .sie_tx_ack(sie_tx_ack),
    .sie_tx_err(sie_tx_err));

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_n

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    `CHK(sie_nak, 1'b1)
    rd(ST); `CHK(rv, UBIN_EP4_STATUS_RST)
  endtask : t_reset
  task automatic t_pio;
    for (int i = 0; i < 63; i++) wr(DT, 8'(i));
    wait_n(2); `CHK(sie_nak, 1'b1)
    wr(DT, 8'h3F); wait_n(2); `CHK(sie_nak, 1'b0)
    rd(UBIN_BULK_IN_CTL_OFS); `CHK(rv[UBIN_IN_NAK_BIT], 1'b1)
    for (int i = 0; i < 64; i++) wr(DT, 8'(64 + i));
    i_ubin_sie_model.take(64, 1'b1);
    `CHK(i_ubin_sie_model.rx[63], 8'h3F)
    wait_n(2); `CHK(sie_nak, 1'b0)
    i_ubin_sie_model.take(64, 1'b0);
    `CHK(i_ubin_sie_model.rx[0], 8'h40)
    wait_n(2); `CHK(sie_nak, 1'b1)
  endtask : t_pio
  task automatic t_short;
    for (int i = 0; i < 3; i++) wr(DT, 8'(160 + i));
    wait_n(2); `CHK(sie_nak, 1'b1)
    wr(UBIN_DATA_END_OFS, 8'h02); wait_n(2); `CHK(sie_nak, 1'b0)
    i_ubin_sie_model.take(3, 1'b0);
    `CHK(i_ubin_sie_model.rx[2], 8'hA2)
    wr(DT, 8'h55); wr(UBIN_DATA_END_OFS, 8'h02);
    wait_n(2); `CHK(sie_nak, 1'b0)
    wr(UBIN_BULK_IN_CTL_OFS, 8'h01); wait_n(1); `CHK(sie_nak, 1'b1)
    i_ubin_sie_model.token(); wait_n(4); `CHK(sie_tx_valid, 1'b0)
  endtask : t_short
  task automatic t_dma;
    for (int i = 0; i < 5; i++) wr(DT, 8'(16 + i));
    wr(UBIN_DMA_CTL_OFS, 8'h01); wait_n(1); `CHK(dma_req, 1'b1)
    for (int i = 5; i < 64; i++) begin
      @(posedge clock);
      dma_wr <= 1'b1; dma_wdata <= 8'(16 + i);
    end
    @(posedge clock);
    dma_wr <= 1'b0;
    wait_n(2); `CHK(dma_req, 1'b0)
    `CHK(sie_nak, 1'b1)
    i_ubin_sie_model.token(); wait_n(4); `CHK(sie_tx_valid, 1'b0)
    wr(UBIN_DATA_END_OFS, 8'h02); wait_n(2); `CHK(sie_nak, 1'b0)
    `CHK(dma_req, 1'b1)
    i_ubin_sie_model.take(64, 1'b1);
    `CHK(i_ubin_sie_model.rx[63], 8'h4F)
    @(posedge clock);
    dma_terminal_count <= 1'b1;
    wait_n(4); `CHK(dma_req, 1'b0)
    @(posedge clock);
    dma_terminal_count <= 1'b0;
    wait_n(3); `CHK(dma_req, 1'b0)
    wr(UBIN_DMA_CTL_OFS, 8'h01); wait_n(2); `CHK(dma_req, 1'b1)
  endtask : t_dma
  task automatic t_status;
    wr(ST, 8'h01); rd(ST); `CHK(rv, 8'h00)
    @(posedge clock);
    ep0_nak_all <= 1'b1;
    wait_n(3); wr(ST, 8'h01); rd(ST); `CHK(rv, 8'h01)
    @(posedge clock);
    ep4_usb_access <= 1'b1; reg_addr <= ST; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0; reg_wr <= 1'b1; reg_wdata <= 8'h00;
    @(posedge clock);
    reg_wr <= 1'b0; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0; ep4_usb_access <= 1'b0;
    #1 `CHK(reg_rdata, 8'h01)
    @(posedge clock);
    ep4_xfer_active <= 1'b1;
    wr(ST, 8'h00); rd(ST); `CHK(rv, 8'h01)
    @(posedge clock);
    ep4_xfer_active <= 1'b0; get_status_ep4 <= 1'b1;
    @(posedge clock);
    get_status_ep4 <= 1'b0;
    #1 `CHK(status_reply_valid, 1'b1)
    `CHK(status_reply, 8'h01)
    wr(ST, 8'h00); wr(UBIN_BULK_OUT_CTL_OFS, 8'h02);
    wait_n(1); `CHK(bulk_out2_nak_ctl, 1'b1)
    c0 = clr_cnt;
    @(posedge clock);
    ep4_error <= 1'b1;
    @(posedge clock);
    ep4_error <= 1'b0;
    wait_n(3); `CHK(clr_cnt, c0 + 1)
    `CHK(bulk_out2_nak_ctl, 1'b0)
    rd(ST); `CHK(rv[UBIN_HALT_BIT], 1'b1)
    rd(32'h00200200); `CHK(rv, 8'h00)
  endtask : t_status

  task automatic give_verdict;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    wait_n(1);
    t_reset();
    t_pio();
    t_short();
    t_dma();
    t_status();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    give_verdict();
  end
endmodule : tb_top

//--- verification/ubin_ctrl_properties.sv
// Concurrent checks on the ports of the bulk IN / endpoint-4 status block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
module ubin_ctrl_properties
  import ubin_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [31:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        dma_terminal_count,
  input wire logic        dma_req,
  input wire logic        sie_nak,
  input wire logic [7:0]  sie_tx_data,
  input wire logic        sie_tx_valid,
  input wire logic        sie_tx_ready,
  input wire logic        sie_tx_last,
  input wire logic        ep4_usb_access,
  input wire logic        ep4_xfer_active,
  input wire logic        ep4_error,
  input wire logic        get_status_ep4,
  input wire logic        status_reply_valid,
  input wire logic        bulk_out2_clear,
  input wire logic        bulk_out2_nak_ctl
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  wire st_rd = reg_rd && reg_addr == UBIN_EP4_STATUS_LOW_OFS && !ep4_error;
  wire st_wr_blk = reg_wr && reg_addr == UBIN_EP4_STATUS_LOW_OFS && !ep4_error
                   && (ep4_usb_access || ep4_xfer_active);

  // ---------------------------------------------------------------
  // Assertions and covers
  // ---------------------------------------------------------------
  a_reply_pulse: assert property (
    status_reply_valid == $past(get_status_ep4))
    else $error("status reply not one cycle after request");
  a_tc_drops_req: assert property (
    $rose(dma_terminal_count) |-> ##[1:4] !dma_req ##1 !dma_req)
    else $error("dma request not dropped after terminal count");
  a_clear_pulse: assert property (
    bulk_out2_clear |=> !bulk_out2_clear)
    else $error("bulk out clear longer than one cycle");
  a_out_nak_low: assert property (
    bulk_out2_clear |-> ##[0:1] !bulk_out2_nak_ctl)
    else $error("bulk out nak not cleared on stall");
  a_valid_needs_nak: assert property (
    $rose(sie_tx_valid) |-> !sie_nak)
    else $error("data offered while endpoint answers nak");
  a_last_sending: assert property (
    sie_tx_last |-> !sie_nak)
    else $error("last byte flagged while endpoint answers nak");
  a_tx_hold: assert property (
    sie_tx_valid && !sie_tx_ready |=> sie_tx_valid && $stable(sie_tx_data))
    else $error("transmit byte lost while stalled");
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_wr_blocked: assert property (
    st_rd ##1 st_wr_blk ##1 st_rd |=> reg_rdata == $past(reg_rdata, 2))
    else $error("status write taken during usb access");

  c_last_byte: cover property (sie_tx_valid && sie_tx_ready && sie_tx_last);
  c_req_fall:  cover property ($fell(dma_req));
  c_reply:     cover property (status_reply_valid);
endmodule : ubin_ctrl_properties

bind ubin_ctrl ubin_ctrl_properties i_ubin_ctrl_properties (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_terminal_count(dma_terminal_count),
  .dma_req(dma_req), .sie_nak(sie_nak), .sie_tx_data(sie_tx_data),
  .sie_tx_valid(sie_tx_valid), .sie_tx_ready(sie_tx_ready), .sie_tx_last(sie_tx_last),
  .ep4_usb_access(ep4_usb_access), .ep4_xfer_active(ep4_xfer_active),
  .ep4_error(ep4_error), .get_status_ep4(get_status_ep4),
  .status_reply_valid(status_reply_valid), .bulk_out2_clear(bulk_out2_clear),
  .bulk_out2_nak_ctl(bulk_out2_nak_ctl));

//--- verification/ubin_sie_model.sv
// Serial engine model: issues IN tokens, takes bytes, acknowledges packets.
// Assumes the block's clock; ready may stall every other cycle.
`timescale 1ns/100ps
module ubin_sie_model (
  input  wire logic       clock,
  input  wire logic [7:0] sie_tx_data,
  input  wire logic       sie_tx_valid,
  output logic            sie_in_token,
  output logic            sie_tx_ready,
  output logic            sie_tx_ack,
  output logic            sie_tx_err
);
  logic [7:0] rx [0:63];
  int         rx_n;

  initial begin
    sie_in_token = 1'b0;
    sie_tx_ready = 1'b0;
    sie_tx_ack   = 1'b0;
    sie_tx_err   = 1'b0;
  end

  task automatic token;
    @(posedge clock);
    sie_in_token <= 1'b1;
    @(posedge clock);
    sie_in_token <= 1'b0;
  endtask : token

  // Takes n bytes, stalling when slow, then acknowledges the packet
  task automatic take(input int n, input bit slow);
    int w;
    rx_n = 0;
    w = 0;
    token();
    while (rx_n < n && w < 1000) begin
      @(posedge clock);
      if (sie_tx_valid && sie_tx_ready) begin
        rx[rx_n] = sie_tx_data;
        rx_n++;
      end
      sie_tx_ready <= slow ? ~sie_tx_ready : 1'b1;
      w++;
    end
    @(posedge clock);
    sie_tx_ready <= 1'b0;
    sie_tx_ack   <= 1'b1;
    @(posedge clock);
    sie_tx_ack <= 1'b0;
  endtask : take
endmodule : ubin_sie_model
